// ---- hdl/srtq_top.sv ----
// slew rate trigger qualifier: registers, transit timer and trigger
//
// Decided for this implementation: the address map and the plain strobed port.
`include "srtq_map.svh"
`timescale 1ns/10ps
`default_nettype none
module srtq_top #(
   parameter int N_CH = 4,
   parameter int CNT_W = 32
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [4:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire srtq_pkg::srtq_cmp_t [N_CH-1:0] cmp_in,
   input wire logic holdoff_busy,
   output logic trig_out,
   output logic trig_rising,
   output logic [1:0] pulse_src_sel
);
   import srtq_pkg::*;
   srtq_ctrl_t ctrl_reg;
   logic [15:0] upper_reg;
   logic [15:0] lower_reg;
   logic [31:0] delta_reg;
   logic recalc_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic [CNT_W-1:0] transit;
   logic [CNT_W-1:0] last_transit_reg;
   logic [15:0] trig_cnt_reg;
   srtq_state_t state_reg;
   srtq_state_t state_next;
   srtq_cmp_t cmp_sel;
   logic hi;
   logic lo;
   logic rise_ok;
   logic fall_ok;
   logic done_rise;
   logic done_fall;
   logic pass;
   logic [16:0] span;
   logic [31:0] dividend;
   logic [31:0] slew_quot;
   logic div_busy;
   logic wr_ctrl;
   logic wr_upper;
   logic wr_lower;
   logic wr_delta;
   logic wr_preset;

   assign wr_ctrl = reg_wr && (reg_addr == `SRTQ_OFS_CTRL);
   assign wr_upper = reg_wr && (reg_addr == `SRTQ_OFS_UPPER);
   assign wr_lower = reg_wr && (reg_addr == `SRTQ_OFS_LOWER);
   assign wr_delta = reg_wr && (reg_addr == `SRTQ_OFS_DELTA);
   assign wr_preset = reg_wr && (reg_addr == `SRTQ_OFS_PRESET);

   // control register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl_reg <= '0;
      end else if (wr_ctrl) begin
         ctrl_reg.enable <= reg_wdata[`SRTQ_CTRL_EN_BIT];
         ctrl_reg.pol <= srtq_pol_t'(reg_wdata[`SRTQ_CTRL_POL_LSB +: 2]);
         ctrl_reg.slower <= reg_wdata[`SRTQ_CTRL_SLOWER_BIT];
         ctrl_reg.src <= reg_wdata[`SRTQ_CTRL_SRC_LSB +: 2];
      end
   end

   // shared source select leaves the block for the other pulse classes
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pulse_src_sel <= 2'h0;
      end else begin
         pulse_src_sel <= ctrl_reg.src;
      end
   end

   // thresholds: separate writes or a logic family preset
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         upper_reg <= `SRTQ_UPPER_RST;
         lower_reg <= `SRTQ_LOWER_RST;
      end else if (wr_preset && reg_wdata[`SRTQ_PRESET_TTL_BIT]) begin
         upper_reg <= `SRTQ_TTL_UPPER;
         lower_reg <= `SRTQ_TTL_LOWER;
      end else if (wr_preset && reg_wdata[`SRTQ_PRESET_ECL_BIT]) begin
         upper_reg <= `SRTQ_ECL_UPPER;
         lower_reg <= `SRTQ_ECL_LOWER;
      end else begin
         if (wr_upper) begin
            upper_reg <= reg_wdata[15:0];
         end
         if (wr_lower) begin
            lower_reg <= reg_wdata[15:0];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         delta_reg <= `SRTQ_DELTA_RST;
      end else if (wr_delta) begin
         delta_reg <= reg_wdata;
      end
   end

   // any change of span or delta restarts the readout division
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         recalc_reg <= 1'b1;
      end else begin
         recalc_reg <= wr_upper || wr_lower || wr_delta || wr_preset;
      end
   end

   // span in threshold codes, fixed point, over delta in cycles
   assign span = {upper_reg[15], upper_reg} - {lower_reg[15], lower_reg};
   assign dividend = span[16] ? 32'h0000_0000 :
      {8'h00, span[15:0], 8'h00};

   srtq_div u_div (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .start(recalc_reg),
      .dividend(dividend),
      .divisor(delta_reg),
      .quot(slew_quot),
      .busy(div_busy)
   );

   srtq_chsel #(
      .N_CH(N_CH)
   ) u_chsel (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .cmp_in(cmp_in),
      .src(ctrl_reg.src),
      .cmp_sel(cmp_sel)
   );

   assign hi = cmp_sel.above_upper;
   assign lo = !cmp_sel.above_lower && !cmp_sel.above_upper;
   assign rise_ok = (ctrl_reg.pol != POL_NEG);
   assign fall_ok = (ctrl_reg.pol != POL_POS);

   // transit state machine
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      done_rise = 1'b0;
      done_fall = 1'b0;
      case (state_reg)
         S_IDLE: begin
            if (hi) begin
               state_next = S_HIGH;
            end else if (lo) begin
               state_next = S_LOW;
            end
         end
         S_LOW: begin
            // both crossed in one sample: too fast to time
            if (hi) begin
               state_next = S_HIGH;
            end else if (!lo) begin
               state_next = rise_ok ? S_RISE : S_IDLE;
               cnt_next = '0;
            end
         end
         S_HIGH: begin
            if (lo) begin
               state_next = S_LOW;
            end else if (!hi) begin
               state_next = fall_ok ? S_FALL : S_IDLE;
               cnt_next = '0;
            end
         end
         S_RISE: begin
            if (lo) begin
               state_next = S_LOW;
            end else if (hi) begin
               state_next = S_HIGH;
               done_rise = 1'b1;
            end else if (cnt_reg != '1) begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         S_FALL: begin
            if (hi) begin
               state_next = S_HIGH;
            end else if (lo) begin
               state_next = S_LOW;
               done_fall = 1'b1;
            end else if (cnt_reg != '1) begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
      if (!ctrl_reg.enable) begin
         state_next = S_IDLE;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_reg <= S_IDLE;
         cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // cycles from first crossing sample to second crossing sample
   assign transit = (cnt_reg == '1) ? cnt_reg : cnt_reg + 1'b1;
   assign pass = (transit >= CNT_W'(`SRTQ_MIN_EDGE_CYC)) &&
      (ctrl_reg.slower ? (transit > CNT_W'(delta_reg)) :
      (transit < CNT_W'(delta_reg)));

   // trigger pulse, gated by the shared mode and holdoff logic
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         trig_out <= 1'b0;
         trig_rising <= 1'b0;
      end else begin
         trig_out <= ctrl_reg.enable && (done_rise || done_fall) &&
            pass && !holdoff_busy;
         if (done_rise || done_fall) begin
            trig_rising <= done_rise;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         last_transit_reg <= '0;
         trig_cnt_reg <= 16'h0000;
      end else begin
         if (ctrl_reg.enable && (done_rise || done_fall)) begin
            last_transit_reg <= transit;
         end
         if (ctrl_reg.enable && (done_rise || done_fall) && pass &&
             !holdoff_busy) begin
            trig_cnt_reg <= trig_cnt_reg + 16'h0001;
         end
      end
   end

   // read port: data only in the cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `SRTQ_OFS_CTRL: reg_rdata <= {26'h0, ctrl_reg.src,
               ctrl_reg.slower, ctrl_reg.pol, ctrl_reg.enable};
            `SRTQ_OFS_UPPER: reg_rdata <= {16'h0000, upper_reg};
            `SRTQ_OFS_LOWER: reg_rdata <= {16'h0000, lower_reg};
            `SRTQ_OFS_DELTA: reg_rdata <= delta_reg;
            `SRTQ_OFS_SLEW: reg_rdata <= slew_quot;
            `SRTQ_OFS_STATUS: reg_rdata <= {trig_cnt_reg, 9'h000,
               state_reg, trig_rising, div_busy};
            `SRTQ_OFS_TRANSIT: reg_rdata <= 32'(last_transit_reg);
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   property p_pos_rising;
      trig_out && (ctrl_reg.pol == POL_POS) |-> trig_rising;
   endproperty
   a_pos_rising: assert property (p_pos_rising)
      else $error("positive trigger on falling edge");

   property p_neg_falling;
      trig_out && (ctrl_reg.pol == POL_NEG) |-> !trig_rising;
   endproperty
   a_neg_falling: assert property (p_neg_falling)
      else $error("negative trigger on rising edge");

   property p_either_both;
      (state_reg == S_HIGH) && (ctrl_reg.pol == POL_EITHER) &&
      ctrl_reg.enable && !hi && !lo |=> (state_reg == S_FALL);
   endproperty
   a_either_both: assert property (p_either_both)
      else $error("either polarity did not time falling edge");

   property p_faster;
      trig_out && !ctrl_reg.slower |-> last_transit_reg < delta_reg;
   endproperty
   a_faster: assert property (p_faster)
      else $error("faster trigger on slow edge");

   property p_slower;
      trig_out && ctrl_reg.slower |-> last_transit_reg > delta_reg;
   endproperty
   a_slower: assert property (p_slower)
      else $error("slower trigger on fast edge");

   property p_trig_at_last;
      trig_out |-> (trig_rising ? $past(hi) : $past(lo));
   endproperty
   a_trig_at_last: assert property (p_trig_at_last)
      else $error("trigger not at last threshold");

   property p_min_edge;
      trig_out |-> last_transit_reg >= `SRTQ_MIN_EDGE_CYC;
   endproperty
   a_min_edge: assert property (p_min_edge)
      else $error("trigger on too fast transit");

   property p_preset_ttl;
      wr_preset && reg_wdata[`SRTQ_PRESET_TTL_BIT] |=>
      (upper_reg == `SRTQ_TTL_UPPER) && (lower_reg == `SRTQ_TTL_LOWER);
   endproperty
   a_preset_ttl: assert property (p_preset_ttl)
      else $error("preset did not load both thresholds");

   property p_recalc;
      wr_delta |-> ##2 div_busy ##[1:40] !div_busy;
   endproperty
   a_recalc: assert property (p_recalc)
      else $error("slew readout not recomputed");

   property p_holdoff;
      trig_out |-> !$past(holdoff_busy);
   endproperty
   a_holdoff: assert property (p_holdoff)
      else $error("trigger during holdoff");

   property p_abandon;
      (state_reg == S_RISE) && lo && ctrl_reg.enable |=>
      (state_reg == S_LOW) && !trig_out;
   endproperty
   a_abandon: assert property (p_abandon)
      else $error("recross did not abandon measurement");

   property p_src;
      ##1 pulse_src_sel == $past(ctrl_reg.src);
   endproperty
   a_src: assert property (p_src)
      else $error("shared source select mismatch");

   c_rise: cover property (trig_out && trig_rising);
   c_fall: cover property (trig_out && !trig_rising);
   c_abandon: cover property ((state_reg == S_FALL) && hi);
   c_preset: cover property (wr_preset ##1 recalc_reg);
endmodule // srtq_top
`default_nettype wire

// ---- hdl/srtq_map.svh ----
// register map, reset values and timing counts of the slew rate qualifier
`ifndef SRTQ_MAP_SVH
`define SRTQ_MAP_SVH
`define SRTQ_OFS_CTRL 5'h00
`define SRTQ_OFS_UPPER 5'h04
`define SRTQ_OFS_LOWER 5'h08
`define SRTQ_OFS_DELTA 5'h0c
`define SRTQ_OFS_PRESET 5'h10
`define SRTQ_OFS_SLEW 5'h14
`define SRTQ_OFS_STATUS 5'h18
`define SRTQ_OFS_TRANSIT 5'h1c
`define SRTQ_CTRL_EN_BIT 0
`define SRTQ_CTRL_POL_LSB 1
`define SRTQ_CTRL_SLOWER_BIT 3
`define SRTQ_CTRL_SRC_LSB 4
`define SRTQ_PRESET_TTL_BIT 0
`define SRTQ_PRESET_ECL_BIT 1
`define SRTQ_UPPER_RST 16'h07d0
`define SRTQ_LOWER_RST 16'h0320
`define SRTQ_DELTA_RST 32'h0000_000c
`define SRTQ_TTL_UPPER 16'h07d0
`define SRTQ_TTL_LOWER 16'h0320
`define SRTQ_ECL_UPPER 16'hfbb4
`define SRTQ_ECL_LOWER 16'hf9c0
`define SRTQ_SLEW_FRAC 8
`define SRTQ_CLK_PS 20000
`define SRTQ_MIN_EDGE_PS 600
`define SRTQ_MIN_PULSE_PS 7500
`define SRTQ_MIN_EDGE_CYC \
   ((`SRTQ_MIN_EDGE_PS + `SRTQ_CLK_PS - 1) / `SRTQ_CLK_PS)
`define SRTQ_MIN_PULSE_CYC \
   ((`SRTQ_MIN_PULSE_PS + `SRTQ_CLK_PS - 1) / `SRTQ_CLK_PS)
`define SRTQ_DIV_STEPS 6'h20
`endif

// ---- hdl/srtq_pkg.sv ----
// types of the slew rate qualifier
package srtq_pkg;
   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_LOW = 5'h02,
      S_HIGH = 5'h04,
      S_RISE = 5'h08,
      S_FALL = 5'h10
   } srtq_state_t;
   typedef enum logic [1:0] {
      POL_POS = 2'h0,
      POL_NEG = 2'h1,
      POL_EITHER = 2'h2
   } srtq_pol_t;
   typedef struct packed {
      logic above_upper;
      logic above_lower;
   } srtq_cmp_t;
   typedef struct packed {
      logic [1:0] src;
      logic slower;
      srtq_pol_t pol;
      logic enable;
   } srtq_ctrl_t;
endpackage

// ---- hdl/srtq_chsel.sv ----
// source channel selection of comparator pairs
`timescale 1ns/10ps
`default_nettype none
module srtq_chsel #(
   parameter int N_CH = 4
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire srtq_pkg::srtq_cmp_t [N_CH-1:0] cmp_in,
   input wire logic [$clog2(N_CH)-1:0] src,
   output srtq_pkg::srtq_cmp_t cmp_sel
);
   import srtq_pkg::*;
   // one shared source for every pulse class; sampled once per cycle
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cmp_sel <= '0;
      end else begin
         cmp_sel <= cmp_in[src];
      end
   end
endmodule // srtq_chsel
`default_nettype wire

// ---- hdl/srtq_div.sv ----
// sequential restoring divider for the slew readout
`include "srtq_map.svh"
`timescale 1ns/10ps
`default_nettype none
module srtq_div (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [31:0] dividend,
   input wire logic [31:0] divisor,
   output logic [31:0] quot,
   output logic busy
);
   import srtq_pkg::*;
   logic [32:0] rem_reg;
   logic [31:0] dvd_reg;
   logic [31:0] dvs_reg;
   logic [5:0] cnt_reg;
   logic [32:0] trial;
   logic [32:0] diff;
   logic fits;
   assign trial = {rem_reg[31:0], dvd_reg[31]};
   assign diff = trial - {1'b0, dvs_reg};
   assign fits = !diff[32];
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rem_reg <= '0;
         dvd_reg <= '0;
         dvs_reg <= '0;
         cnt_reg <= '0;
         busy <= 1'b0;
         quot <= '0;
      end else if (start) begin
         rem_reg <= '0;
         dvd_reg <= dividend;
         dvs_reg <= divisor;
         cnt_reg <= `SRTQ_DIV_STEPS;
         busy <= 1'b1;
      end else if (busy) begin
         rem_reg <= fits ? diff : trial;
         dvd_reg <= {dvd_reg[30:0], fits};
         cnt_reg <= cnt_reg - 6'h01;
         if (cnt_reg == 6'h01) begin
            busy <= 1'b0;
            quot <= {dvd_reg[30:0], fits};
         end
      end
   end
endmodule // srtq_div
`default_nettype wire

// ---- tb/srtq_cmp_model.sv ----
// behavioural threshold comparator pairs on the far side of the qualifier
`timescale 1ns/10ps
`default_nettype none
module srtq_cmp_model #(
   parameter int N_CH = 4
) (
   input wire logic ref_clk,
   input wire logic [N_CH-1:0][15:0] level,
   input wire logic [15:0] thr_upper,
   input wire logic [15:0] thr_lower,
   output srtq_pkg::srtq_cmp_t [N_CH-1:0] cmp_out
);
   import srtq_pkg::*;
   // comparators settle once per sample, signed codes
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < N_CH; i++) begin
         cmp_out[i].above_upper <= $signed(level[i]) > $signed(thr_upper);
         cmp_out[i].above_lower <= $signed(level[i]) > $signed(thr_lower);
      end
   end
endmodule // srtq_cmp_model
`default_nettype wire

// ---- tb/srtq_top_tb.sv ----
// self-checking bench of the slew rate qualifier
`include "srtq_map.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin \
   failures++; $display("wrong value at %0t: %s", $time, m); end end
module srtq_top_tb;
   import srtq_pkg::*;
   localparam logic [2:0][15:0] LV = {16'h0bb8, 16'h0578, 16'h0000};
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] reg_addr = 5'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic holdoff_busy = 1'b0;
   logic [3:0][15:0] level = '0;
   logic [15:0] thr_u = 16'h07d0;
   logic [15:0] thr_l = 16'h0320;
   srtq_cmp_t [3:0] cmp_in;
   logic [31:0] reg_rdata;
   logic trig_out;
   logic trig_rising;
   logic [1:0] pulse_src_sel;
   logic [31:0] rv;
   int failures = 0;
   int checked = 0;

   always #10 ref_clk = ~ref_clk;

   srtq_cmp_model srtq_cmp_model_i (.ref_clk(ref_clk), .level(level),
      .thr_upper(thr_u), .thr_lower(thr_l), .cmp_out(cmp_in));
   srtq_top srtq_top_i (.ref_clk(ref_clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_in(cmp_in),
      .holdoff_busy(holdoff_busy), .trig_out(trig_out),
      .trig_rising(trig_rising), .pulse_src_sel(pulse_src_sel));

   task automatic give_verdict();
      if (failures == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      rv = reg_rdata;
   endtask

   task automatic wait_div();
      repeat (3) @(posedge ref_clk);
      for (int i = 0; i < 60; i++) begin
         rd(`SRTQ_OFS_STATUS);
         if (rv[0] === 1'b0) return;
      end
      failures++;
      give_verdict();
   endtask

   task automatic ctrl(input logic [1:0] src, input logic slow,
                       input srtq_pol_t pol);
      wr(`SRTQ_OFS_CTRL, {26'h0, src, slow, pol, 1'b1});
   endtask

   // start zone s, k samples in the middle zone, then end zone e
   task automatic edge_run(input int ch, input int s, input int e,
                           input int k, input int exp_n,
                           input logic exp_dir);
      int n;
      n = 0;
      @(posedge ref_clk);
      level[ch] <= LV[s];
      repeat (4) @(posedge ref_clk);
      if (k > 0) begin
         level[ch] <= LV[1];
         repeat (k) @(posedge ref_clk);
      end
      level[ch] <= LV[e];
      repeat (8) begin
         @(negedge ref_clk);
         if (trig_out === 1'b1) n++;
      end
      `CHK(n, exp_n, "trigger count")
      if (exp_n > 0) `CHK(trig_rising, exp_dir, "edge direction")
   endtask

   task automatic t_regs();
      rd(`SRTQ_OFS_CTRL);
      `CHK(rv, 32'h0, "control reset")
      rd(`SRTQ_OFS_DELTA);
      `CHK(rv, `SRTQ_DELTA_RST, "delta reset")
      rd(5'h02);
      `CHK(rv, 32'h0, "unmapped read")
      wr(`SRTQ_OFS_UPPER, 32'h0000_0900);
      rd(`SRTQ_OFS_UPPER);
      `CHK(rv[15:0], 16'h0900, "upper write")
      rd(`SRTQ_OFS_LOWER);
      `CHK(rv[15:0], `SRTQ_LOWER_RST, "lower untouched")
      wr(`SRTQ_OFS_UPPER, {16'h0, `SRTQ_UPPER_RST});
   endtask

   task automatic t_slew();
      wait_div();
      rd(`SRTQ_OFS_SLEW);
      `CHK(rv, 32'h0000_6400, "slew default")
      wr(`SRTQ_OFS_SLEW, 32'h0);
      rd(`SRTQ_OFS_SLEW);
      `CHK(rv, 32'h0000_6400, "slew write ignored")
      wr(`SRTQ_OFS_DELTA, 32'h20);
      wait_div();
      rd(`SRTQ_OFS_SLEW);
      `CHK(rv, 32'h0000_2580, "slew after delta")
      wr(`SRTQ_OFS_DELTA, `SRTQ_DELTA_RST);
      wait_div();
   endtask

   task automatic t_pos();
      ctrl(2'h0, 1'b0, POL_POS);
      edge_run(0, 0, 2, 2, 1, 1'b1);
      rd(`SRTQ_OFS_TRANSIT);
      `CHK(rv, 32'h2, "transit count")
      edge_run(0, 2, 0, 2, 0, 1'b0);
      edge_run(0, 0, 2, 11, 1, 1'b1);
      edge_run(0, 0, 2, 12, 0, 1'b0);
   endtask

   task automatic t_neg_either();
      ctrl(2'h0, 1'b0, POL_NEG);
      edge_run(0, 2, 0, 3, 1, 1'b0);
      edge_run(0, 0, 2, 3, 0, 1'b0);
      ctrl(2'h0, 1'b0, POL_EITHER);
      edge_run(0, 0, 2, 3, 1, 1'b1);
      edge_run(0, 2, 0, 3, 1, 1'b0);
   endtask

   task automatic t_slower();
      ctrl(2'h0, 1'b1, POL_POS);
      edge_run(0, 0, 2, 13, 1, 1'b1);
      edge_run(0, 0, 2, 12, 0, 1'b0);
      edge_run(0, 0, 2, 5, 0, 1'b0);
   endtask

   task automatic t_faults();
      ctrl(2'h0, 1'b0, POL_POS);
      edge_run(0, 0, 0, 3, 0, 1'b0);
      edge_run(0, 0, 2, 0, 0, 1'b0);
      @(posedge ref_clk);
      holdoff_busy <= 1'b1;
      edge_run(0, 0, 2, 3, 0, 1'b0);
      @(posedge ref_clk);
      holdoff_busy <= 1'b0;
      edge_run(0, 0, 2, 3, 1, 1'b1);
      wr(`SRTQ_OFS_CTRL, 32'h0);
      edge_run(0, 0, 2, 3, 0, 1'b0);
   endtask

   task automatic t_src();
      ctrl(2'h2, 1'b0, POL_POS);
      edge_run(0, 0, 2, 3, 0, 1'b0);
      edge_run(2, 0, 2, 3, 1, 1'b1);
      `CHK(pulse_src_sel, 2'h2, "shared source")
      rd(`SRTQ_OFS_STATUS);
      `CHK(rv[31:16], 16'h0008, "passed trigger count")
   endtask

   task automatic t_preset();
      wr(`SRTQ_OFS_PRESET, 32'h2);
      thr_u <= `SRTQ_ECL_UPPER;
      thr_l <= `SRTQ_ECL_LOWER;
      rd(`SRTQ_OFS_UPPER);
      `CHK(rv[15:0], `SRTQ_ECL_UPPER, "family upper")
      rd(`SRTQ_OFS_LOWER);
      `CHK(rv[15:0], `SRTQ_ECL_LOWER, "family lower")
      wait_div();
      rd(`SRTQ_OFS_SLEW);
      `CHK(rv, 32'h0000_29aa, "slew after preset")
      wr(`SRTQ_OFS_PRESET, 32'h3);
      thr_u <= `SRTQ_TTL_UPPER;
      thr_l <= `SRTQ_TTL_LOWER;
      rd(`SRTQ_OFS_UPPER);
      `CHK(rv[15:0], `SRTQ_TTL_UPPER, "both presets")
   endtask

   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      t_regs();
      t_slew();
      t_pos();
      t_neg_either();
      t_slower();
      t_faults();
      t_src();
      t_preset();
      give_verdict();
   end
endmodule // srtq_top_tb
`default_nettype wire
